// file: verilog/npc_regs.sv
/*
  npc_regs: read-only namespace protection capability, protection setting
  and sharing capability bytes, plus the configuration registers that
  firmware uses to load them.
  Assumes a single synchronous master on a plain strobe port; read data
  appear the cycle after the read strobe and only then.
*/
// Operation
// - several protection capability bits may be set together; bits 7:5 reserved.
// - capability bit 4 set exactly when last eight metadata bytes supported.
// - capability bit 3 set exactly when first eight metadata bytes supported.
// - capability bits 2,1,0 set exactly when types 3,2,1 supported.
// - setting bit 3 is 1 for first eight bytes, 0 for last eight.
// - setting bits 2:0 give off or type 1..3; codes 100b-111b never reported.
// - setting bits 7:4 reserved.
// - sharing bit 0 set when namespace may attach to several controllers.
// - sharing bit 0 clear when private; bits 7:1 reserved.
`timescale 1ns/1ps
module npc_regs (
  // clock and reset
  input  wire logic       MCLK_I,
  input  wire logic       ARST_N_I,
  // register port
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  // reported bytes
  output logic      [7:0] PROT_CAP_O,
  output logic      [7:0] PROT_SET_O,
  output logic      [7:0] SHARE_CAP_O
);

  logic [7:0] prot_cap;
  logic [7:0] prot_set;
  logic [7:0] share_cap;
  logic       reject;
  logic [7:0] rdata;
  logic       set_legal;
  logic       cand_legal;

  // one place for address matching; write and read decode share the offsets
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction : addr_is

  // decode
  wire logic       wr_cap   = WR_I & addr_is(ADDR_I, npc_pkg::OFS_CFG_CAP);
  wire logic       wr_set   = WR_I & addr_is(ADDR_I, npc_pkg::OFS_CFG_SET);
  wire logic       wr_share = WR_I & addr_is(ADDR_I, npc_pkg::OFS_CFG_SHARE);
  wire logic       wr_sts   = WR_I & addr_is(ADDR_I, npc_pkg::OFS_STATUS);
  // the reported bytes are read-only; a write there must leave every byte alone
  wire logic       wr_ro    = WR_I & (addr_is(ADDR_I, npc_pkg::OFS_PROT_CAP)
                                    | addr_is(ADDR_I, npc_pkg::OFS_PROT_SET)
                                    | addr_is(ADDR_I, npc_pkg::OFS_SHARE_CAP));

  // read selects: a reported byte and its config mirror return the same flops
  wire logic       sel_cap     = addr_is(ADDR_I, npc_pkg::OFS_PROT_CAP)
                               | addr_is(ADDR_I, npc_pkg::OFS_CFG_CAP);
  wire logic       sel_set     = addr_is(ADDR_I, npc_pkg::OFS_PROT_SET)
                               | addr_is(ADDR_I, npc_pkg::OFS_CFG_SET);
  wire logic       sel_share   = addr_is(ADDR_I, npc_pkg::OFS_SHARE_CAP)
                               | addr_is(ADDR_I, npc_pkg::OFS_CFG_SHARE);
  wire logic       sel_sts     = addr_is(ADDR_I, npc_pkg::OFS_STATUS);
  wire logic       addr_mapped = sel_cap | sel_set | sel_share | sel_sts;

  // reserved bits are dropped on the way in so they can never read back
  wire logic [7:0] cap_in   = WDATA_I & npc_pkg::CAP_VALID_MASK;
  wire logic [7:0] set_in   = WDATA_I & npc_pkg::SET_VALID_MASK;
  wire logic [7:0] share_in = WDATA_I & npc_pkg::SHARE_VALID_MASK;

  // a setting is checked against the capability that will hold after the write
  wire logic [7:0] cand_cap = wr_cap ? cap_in : prot_cap;
  wire logic [7:0] cand_set = wr_set ? set_in : prot_set;

  npc_check u_check (
    .cap_i   (cand_cap),
    .set_i   (cand_set),
    .legal_o (cand_legal)
  );

  // a capability write that would strand the active setting also disables it
  wire logic       take_set = wr_set & cand_legal;
  wire logic       drop_set = wr_cap & ~wr_set & ~cand_legal;
  wire logic       bad_wr   = (wr_set & ~cand_legal) | drop_set;

  wire logic [7:0] next_prot_cap  = wr_cap ? cap_in : prot_cap;
  wire logic [7:0] next_prot_set  = take_set ? set_in :
                                    drop_set ? npc_pkg::RST_PROT_SET : prot_set;
  wire logic [7:0] next_share_cap = wr_share ? share_in : share_cap;
  // hardware set wins over a software clear in the same cycle
  wire logic       next_reject    = bad_wr | (reject & ~(wr_sts & WDATA_I[npc_pkg::STS_REJECT_BIT]));

  wire logic [7:0] rd_mux =
      sel_cap   ? prot_cap :
      sel_set   ? prot_set :
      sel_share ? share_cap :
      sel_sts   ? {7'h00, reject} :
                  npc_pkg::RST_READ_DATA;
  // read data only in the cycle after the strobe
  wire logic [7:0] next_rdata = RD_I ? rd_mux : npc_pkg::RST_READ_DATA;

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      prot_cap  <= npc_pkg::RST_PROT_CAP;
      prot_set  <= npc_pkg::RST_PROT_SET;
      share_cap <= npc_pkg::RST_SHARE_CAP;
      reject    <= 1'b0;
      rdata     <= npc_pkg::RST_READ_DATA;
    end else begin
      prot_cap  <= next_prot_cap;
      prot_set  <= next_prot_set;
      share_cap <= next_share_cap;
      reject    <= next_reject;
      rdata     <= next_rdata;
    end
  end

  assign RDATA_O     = rdata;
  assign PROT_CAP_O  = prot_cap;
  assign PROT_SET_O  = prot_set;
  assign SHARE_CAP_O = share_cap;

  // live legality of the stored pair, for checking only
  npc_check u_live (
    .cap_i   (prot_cap),
    .set_i   (prot_set),
    .legal_o (set_legal)
  );

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);

  sequence s_cap_write;
    wr_cap;
  endsequence

  sequence s_cap_shows(logic [7:0] v);
    PROT_CAP_O == v;
  endsequence

  sequence s_set_taken;
    take_set;
  endsequence

  sequence s_set_refused;
    wr_set && !cand_legal;
  endsequence

  sequence s_cap_strands;
    drop_set;
  endsequence

  sequence s_status_clear;
    wr_sts && WDATA_I[npc_pkg::STS_REJECT_BIT];
  endsequence

  sequence s_rd_of(logic [7:0] ofs);
    RD_I && (ADDR_I == ofs);
  endsequence

  // capability byte
  a_cap_reserved_zero: assert property (
      PROT_CAP_O[7:5] == 3'b000)
    else $error("capability reserved bits set");

  a_cap_write_lands: assert property (
      s_cap_write |=> s_cap_shows($past(cap_in)))
    else $error("capability write not reflected");

  a_cap_type_bits: assert property (
      wr_cap |=> (PROT_CAP_O[2:0] == $past(WDATA_I[2:0])))
    else $error("type capability bits wrong");

  a_cap_place_bits: assert property (
      wr_cap |=> (PROT_CAP_O[4:3] == $past(WDATA_I[4:3])))
    else $error("placement capability bits wrong");

  a_cap_last8_lands: assert property (
      wr_cap |=> (PROT_CAP_O[npc_pkg::CAP_LAST8_BIT] == $past(WDATA_I[npc_pkg::CAP_LAST8_BIT])))
    else $error("last eight capability bit wrong");

  a_cap_first8_lands: assert property (
      wr_cap |=> (PROT_CAP_O[npc_pkg::CAP_FIRST8_BIT] == $past(WDATA_I[npc_pkg::CAP_FIRST8_BIT])))
    else $error("first eight capability bit wrong");

  a_cap_idle_stable: assert property (
      !wr_cap |=> $stable(PROT_CAP_O))
    else $error("capability changed without a write");

  a_cap_strand_lands: assert property (
      s_cap_strands |=> s_cap_shows($past(cap_in)))
    else $error("stranding capability write not taken");

  // type-settings byte
  a_set_mode_legal: assert property (
      PROT_SET_O[2] == 1'b0)
    else $error("reserved protection mode reported");

  a_set_reserved_zero: assert property (
      PROT_SET_O[7:4] == 4'h0)
    else $error("setting reserved bits set");

  a_set_reserved_write: assert property (
      wr_set |=> (PROT_SET_O[7:4] == 4'h0))
    else $error("setting reserved bits written");

  a_set_matches_cap: assert property (
      set_legal)
    else $error("setting not backed by capability");

  a_set_place_kept: assert property (
      (take_set && WDATA_I[npc_pkg::SET_FIRST8_BIT]) |=>
        PROT_SET_O[3] ##1 (PROT_SET_O[3] || $past(wr_set || wr_cap)))
    else $error("placement bit not kept");

  a_set_write_lands: assert property (
      s_set_taken |=> (PROT_SET_O == $past(set_in)))
    else $error("legal setting not taken");

  a_set_refused_kept: assert property (
      s_set_refused |=> $stable(PROT_SET_O))
    else $error("refused setting changed the byte");

  a_set_idle_stable: assert property (
      !(wr_set || wr_cap) |=> $stable(PROT_SET_O))
    else $error("setting changed without a write");

  a_strand_clears: assert property (
      s_cap_strands |=> (PROT_SET_O == npc_pkg::RST_PROT_SET))
    else $error("stranded setting not disabled");

  // an enabled type must sit where the capability allows
  a_place_first8: assert property (
      (PROT_SET_O[2:0] != npc_pkg::PI_OFF && PROT_SET_O[3]) |->
        PROT_CAP_O[npc_pkg::CAP_FIRST8_BIT])
    else $error("first eight placement not supported");

  a_place_last8: assert property (
      (PROT_SET_O[2:0] != npc_pkg::PI_OFF && !PROT_SET_O[3]) |->
        PROT_CAP_O[npc_pkg::CAP_LAST8_BIT])
    else $error("last eight placement not supported");

  a_type1_backed: assert property (
      (PROT_SET_O[2:0] == npc_pkg::PI_TYPE1) |-> PROT_CAP_O[npc_pkg::CAP_TYPE1_BIT])
    else $error("type 1 not supported");

  a_type2_backed: assert property (
      (PROT_SET_O[2:0] == npc_pkg::PI_TYPE2) |-> PROT_CAP_O[npc_pkg::CAP_TYPE2_BIT])
    else $error("type 2 not supported");

  a_type3_backed: assert property (
      (PROT_SET_O[2:0] == npc_pkg::PI_TYPE3) |-> PROT_CAP_O[npc_pkg::CAP_TYPE3_BIT])
    else $error("type 3 not supported");

  // sharing byte
  a_share_bit_lands: assert property (
      wr_share |=> (SHARE_CAP_O[0] == $past(WDATA_I[0])))
    else $error("sharing bit not reflected");

  a_share_shared: assert property (
      (wr_share && WDATA_I[npc_pkg::SHARE_BIT]) |=> SHARE_CAP_O[npc_pkg::SHARE_BIT])
    else $error("shared namespace not reported");

  a_share_private: assert property (
      (wr_share && !WDATA_I[npc_pkg::SHARE_BIT]) |=> !SHARE_CAP_O[npc_pkg::SHARE_BIT])
    else $error("private namespace not reported");

  a_share_reserved_zero: assert property (
      SHARE_CAP_O[7:1] == 7'h00)
    else $error("sharing reserved bits set");

  a_share_idle_stable: assert property (
      !wr_share |=> $stable(SHARE_CAP_O))
    else $error("sharing changed without a write");

  // status flag: sticky until software clears it
  a_refuse_flags: assert property (
      s_set_refused |=> reject)
    else $error("refused setting not flagged");

  a_strand_flags: assert property (
      s_cap_strands |=> reject)
    else $error("stranding write not flagged");

  a_status_clear: assert property (
      s_status_clear |=> !reject)
    else $error("status flag not cleared");

  a_status_sticky: assert property (
      (reject && !(wr_sts && WDATA_I[npc_pkg::STS_REJECT_BIT])) |=> reject)
    else $error("status flag lost");

  a_ro_write_ignored: assert property (
      wr_ro |=> ($stable(PROT_CAP_O) && $stable(PROT_SET_O) && $stable(SHARE_CAP_O)))
    else $error("read-only byte written");

  // register port read path
  a_read_one_cycle: assert property (
      !$past(RD_I) |-> (RDATA_O == 8'h00))
    else $error("read data outside read cycle");

  a_write_no_rdata: assert property (
      WR_I |=> (RDATA_O == npc_pkg::RST_READ_DATA))
    else $error("read data after a write");

  a_unmapped_read: assert property (
      (RD_I && !addr_mapped) |=> (RDATA_O == npc_pkg::RST_READ_DATA))
    else $error("unmapped read not zero");

  a_read_prot_cap: assert property (
      s_rd_of(npc_pkg::OFS_PROT_CAP) |=> (RDATA_O == $past(PROT_CAP_O)))
    else $error("capability read wrong");

  a_read_prot_set: assert property (
      s_rd_of(npc_pkg::OFS_PROT_SET) |=> (RDATA_O == $past(PROT_SET_O)))
    else $error("setting read wrong");

  a_read_share: assert property (
      s_rd_of(npc_pkg::OFS_SHARE_CAP) |=> (RDATA_O == $past(SHARE_CAP_O)))
    else $error("sharing read wrong");

  a_read_cfg_cap: assert property (
      s_rd_of(npc_pkg::OFS_CFG_CAP) |=> (RDATA_O == $past(PROT_CAP_O)))
    else $error("capability config read wrong");

  a_read_cfg_set: assert property (
      s_rd_of(npc_pkg::OFS_CFG_SET) |=> (RDATA_O == $past(PROT_SET_O)))
    else $error("setting config read wrong");

  a_read_cfg_share: assert property (
      s_rd_of(npc_pkg::OFS_CFG_SHARE) |=> (RDATA_O == $past(SHARE_CAP_O)))
    else $error("sharing config read wrong");

  a_read_status: assert property (
      s_rd_of(npc_pkg::OFS_STATUS) |=> (RDATA_O == {7'h00, $past(reject)}))
    else $error("status read wrong");

endmodule : npc_regs

// file: pkg/npc_pkg.sv
/*
  npc_pkg: offsets, field positions, reset values and encodings of the
  namespace protection and sharing capability bytes.
  Assumes a byte-wide register port with offsets as printed (0x1c..0x1e).
*/
package npc_pkg;

  // register offsets
  localparam logic [7:0] OFS_PROT_CAP   = 8'h1c;
  localparam logic [7:0] OFS_PROT_SET   = 8'h1d;
  localparam logic [7:0] OFS_SHARE_CAP  = 8'h1e;
  localparam logic [7:0] OFS_CFG_CAP    = 8'h40;
  localparam logic [7:0] OFS_CFG_SET    = 8'h41;
  localparam logic [7:0] OFS_CFG_SHARE  = 8'h42;
  localparam logic [7:0] OFS_STATUS     = 8'h43;

  // capability byte fields
  localparam int CAP_TYPE1_BIT   = 0;
  localparam int CAP_TYPE2_BIT   = 1;
  localparam int CAP_TYPE3_BIT   = 2;
  localparam int CAP_FIRST8_BIT  = 3;
  localparam int CAP_LAST8_BIT   = 4;
  localparam logic [7:0] CAP_VALID_MASK = 8'h1f;

  // type-settings byte fields
  localparam int SET_FIRST8_BIT  = 3;
  localparam logic [7:0] SET_VALID_MASK = 8'h0f;

  // sharing byte fields
  localparam int SHARE_BIT       = 0;
  localparam logic [7:0] SHARE_VALID_MASK = 8'h01;

  // status byte fields
  localparam int STS_REJECT_BIT  = 0;

  typedef enum logic [2:0] {
    PI_OFF   = 3'b000,
    PI_TYPE1 = 3'b001,
    PI_TYPE2 = 3'b010,
    PI_TYPE3 = 3'b011
  } npc_pi_mode_t;

  // reset values
  localparam logic [7:0] RST_PROT_CAP  = 8'h00;
  localparam logic [7:0] RST_PROT_SET  = 8'h00;
  localparam logic [7:0] RST_SHARE_CAP = 8'h00;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

endpackage : npc_pkg

// file: verilog/npc_check.sv
/*
  npc_check: decides whether a requested protection setting is legal
  against a capability byte.
  Assumes both bytes are already masked to their defined bits.
*/
`timescale 1ns/1ps
module npc_check (
  // inputs
  input  wire logic [7:0] cap_i,
  input  wire logic [7:0] set_i,
  // result
  output logic            legal_o
);

  wire logic [2:0] mode      = set_i[2:0];
  wire logic       first8    = set_i[npc_pkg::SET_FIRST8_BIT];
  wire logic       type_ok   = (mode == npc_pkg::PI_OFF)
                             | ((mode == npc_pkg::PI_TYPE1) & cap_i[npc_pkg::CAP_TYPE1_BIT])
                             | ((mode == npc_pkg::PI_TYPE2) & cap_i[npc_pkg::CAP_TYPE2_BIT])
                             | ((mode == npc_pkg::PI_TYPE3) & cap_i[npc_pkg::CAP_TYPE3_BIT]);
  // placement only matters once a type is enabled
  wire logic       place_ok  = (mode == npc_pkg::PI_OFF)
                             | (first8 ? cap_i[npc_pkg::CAP_FIRST8_BIT]
                                       : cap_i[npc_pkg::CAP_LAST8_BIT]);

  assign legal_o = type_ok & place_ok;

endmodule : npc_check

// file: sim/npc_tb.sv
/*
  testbench: self-checking bench for npc_regs through its byte register port.
  Assumes read data show only in the cycle after the read strobe and read zero otherwise.
*/
`timescale 1ns/1ps
module testbench;
  logic       mclk;
  logic       arst_n;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [7:0] pcap;
  logic [7:0] pset;
  logic [7:0] share;
  int         miscompares = 0;
  int         checks      = 0;

  npc_regs i_npc_regs (.MCLK_I(mclk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PROT_CAP_O(pcap), .PROT_SET_O(pset),
    .SHARE_CAP_O(share));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // outputs are looked at one step after the edge that takes the write
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr    <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    chk("read data", rdata, exp);
  endtask : rd_reg

  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic t_cap;
    rd_reg(8'h1c, 8'h00);
    wr_reg(8'h40, 8'hff);
    chk("capability", pcap, 8'h1f);
    wr_reg(8'h1c, 8'h00);
    rd_reg(8'h1c, 8'h1f);
    for (int i = 0; i < 5; i++) begin
      wr_reg(8'h40, 8'h01 << i);
      chk("capability bit", pcap, 8'h01 << i);
    end
    $display("test capability done");
  endtask : t_cap

  task automatic t_modes;
    wr_reg(8'h40, 8'h1f);
    rd_reg(8'h40, 8'h1f);
    for (int m = 1; m < 4; m++) begin
      wr_reg(8'h41, 8'h08 | m);
      rd_reg(8'h1d, 8'h08 | m);
    end
    wr_reg(8'h41, 8'hf2);
    chk("setting", pset, 8'h02);
    rd_reg(8'h41, 8'h02);
    wr_reg(8'h41, 8'h0c);
    chk("setting", pset, 8'h02);
    rd_reg(8'h43, 8'h01);
    wr_reg(8'h43, 8'h01);
    rd_reg(8'h43, 8'h00);
    $display("test modes done");
  endtask : t_modes

  task automatic t_legal;
    wr_reg(8'h40, 8'h11);
    wr_reg(8'h41, 8'h01);
    wr_reg(8'h40, 8'h09);
    chk("setting", pset, 8'h00);
    wr_reg(8'h41, 8'h0a);
    chk("setting", pset, 8'h00);
    wr_reg(8'h41, 8'h01);
    chk("setting", pset, 8'h00);
    wr_reg(8'h41, 8'h09);
    chk("setting", pset, 8'h09);
    $display("test legality done");
  endtask : t_legal

  task automatic t_share;
    wr_reg(8'h42, 8'hff);
    rd_reg(8'h1e, 8'h01);
    rd_reg(8'h42, 8'h01);
    @(posedge mclk);
    #1;
    chk("idle read data", rdata, 8'h00);
    wr_reg(8'h42, 8'hfe);
    chk("sharing", share, 8'h00);
    rd_reg(8'h77, 8'h00);
    arst_n <= 1'b0;
    #1;
    chk("capability", pcap, 8'h00);
    chk("setting", pset, 8'h00);
    chk("sharing", share, 8'h00);
    @(posedge mclk);
    arst_n <= 1'b1;
    rd_reg(8'h1d, 8'h00);
    $display("test sharing done");
  endtask : t_share

  initial begin
    repeat (2000) @(posedge mclk);
    miscompares++;
    finish_test();
  end

  initial begin
    arst_n = 1'b0;
    addr   = 8'h00;
    wdata  = 8'h00;
    wr     = 1'b0;
    rd     = 1'b0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    t_cap();
    t_modes();
    t_legal();
    t_share();
    finish_test();
  end
endmodule : testbench
